// ==== scjd_params.svh ====
// Constants for the start-condition jump decoder: opcode fields,
// field positions and reset values, all as macros.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SCJD_PARAMS_SVH
`define SCJD_PARAMS_SVH

// ----------------------------------------------------------------------
// Instruction word layout
// ----------------------------------------------------------------------
`define SCJD_WORD_W        16
`define SCJD_OPC_HI        15
`define SCJD_OPC_LO        11
`define SCJD_SEL_HI        10
`define SCJD_SEL_LO        5
`define SCJD_JREG_BIT      4
`define SCJD_TAIL_HI       3
`define SCJD_TAIL_LO       0
`define SCJD_OFS_HI        4
`define SCJD_OFS_LO        0
`define SCJD_OFS_W         5
`define SCJD_SEL_W         6

// ----------------------------------------------------------------------
// Opcode values
// ----------------------------------------------------------------------
`define SCJD_ABS_OPC       5'h07
`define SCJD_ABS_TAIL      4'h1
`define SCJD_REL_OPC       5'h01
`define SCJD_NO_START      6'h00

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SCJD_PC_RST        0

`endif

// ==== scjd_pkg.sv ====
// Types shared by the start-condition jump decoder modules.
// Assumes the constants header is on the include path.
`include "scjd_params.svh"

package scjd_pkg;

  // ----------------------------------------------------------------------
  // Decoded instruction class, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    SCJD_KIND_OTHER = 3'b001,
    SCJD_KIND_ABS   = 3'b010,
    SCJD_KIND_REL   = 3'b100
  } scjd_kind_type;

endpackage

// ==== scjd_decode.sv ====
// Pure field decoder for the two start-condition jumps.
// Assumes a stable instruction word on the same clock as the caller.
`timescale 1ns/10ps
`include "scjd_params.svh"

module scjd_decode
(
  input  wire logic [15:0]         instr_word,
  output scjd_pkg::scjd_kind_type  kind,
  output wire logic [5:0]          start_select,
  output wire logic                jump_reg_select,
  output wire logic [4:0]          rel_offset
);

  // ----------------------------------------------------------------------
  // Opcode match
  // ----------------------------------------------------------------------
  wire logic [4:0] opc;
  wire logic [3:0] tail;
  wire logic       is_abs;
  wire logic       is_rel;

  assign opc  = instr_word[`SCJD_OPC_HI:`SCJD_OPC_LO];
  assign tail = instr_word[`SCJD_TAIL_HI:`SCJD_TAIL_LO];
  // Tail must be checked: other far jumps share the 00111 prefix
  assign is_abs = (opc == `SCJD_ABS_OPC) && (tail == `SCJD_ABS_TAIL); // [RULE_07]
  assign is_rel = (opc == `SCJD_REL_OPC);                              // [RULE_08]

  assign kind = is_abs ? scjd_pkg::SCJD_KIND_ABS :
                is_rel ? scjd_pkg::SCJD_KIND_REL :
                         scjd_pkg::SCJD_KIND_OTHER;

  // ----------------------------------------------------------------------
  // Operand fields, same place in both formats
  // ----------------------------------------------------------------------
  assign start_select    = instr_word[`SCJD_SEL_HI:`SCJD_SEL_LO];   // [RULE_06]
  assign jump_reg_select = instr_word[`SCJD_JREG_BIT];              // [RULE_03]
  assign rel_offset      = instr_word[`SCJD_OFS_HI:`SCJD_OFS_LO];   // [RULE_05]

endmodule // scjd_decode

// ==== scjd_core.sv ====
// Execute stage for the start-condition jumps: picks the next program
// counter from the decoded word, the latched starts and the jump registers.
// Assumes start latches, jump registers and fetch all run on clk.
//
// Operation
// RULE_01: Absolute jump taken loads the counter from the chosen jump register.
// RULE_02: Absolute target may be any code address; no range check applied.
// RULE_03: Bit 4 selects which jump register supplies the absolute target.
// RULE_04: Relative jump taken sets counter to instruction address plus offset.
// RULE_05: Offset is five-bit two's complement, range minus sixteen to fifteen.
// RULE_06: Six-bit start select, bit 0 is start 1; zero means none latched.
// RULE_07: Absolute form: bits 15..11 00111, select, register bit, tail 0001.
// RULE_08: Relative form: bits 15..11 00001, select, offset in bits 4..0.
// RULE_09: Condition false: either jump falls through to next sequential address.
`timescale 1ns/10ps
`include "scjd_params.svh"

module scjd_core
#(
  parameter int PC_W = 10
)
(
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire logic            clk_en,
  input  wire logic            instr_valid,
  input  wire logic [15:0]     instr_word,
  input  wire logic [PC_W-1:0] instr_addr,
  input  wire logic [5:0]      start_latched,
  input  wire logic [PC_W-1:0] jump_reg0,
  input  wire logic [PC_W-1:0] jump_reg1,
  output logic [PC_W-1:0]      microcore_program_counter,
  output logic                 pc_load,
  output logic                 branch_taken
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Modulo add keeps the counter wrapping inside the code space
  function automatic logic [PC_W-1:0] pc_add
  (
    input logic [PC_W-1:0] base,
    input logic [PC_W-1:0] delta
  );
    pc_add = base + delta;
  endfunction

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  scjd_pkg::scjd_kind_type kind;
  wire logic [5:0]         start_select;
  wire logic               jump_reg_select;
  wire logic [4:0]         rel_offset;

  scjd_decode u_decode
  (
    .instr_word      (instr_word),
    .kind            (kind),
    .start_select    (start_select),
    .jump_reg_select (jump_reg_select),
    .rel_offset      (rel_offset)
  );

  // ----------------------------------------------------------------------
  // Condition and target selection
  // ----------------------------------------------------------------------
  wire logic            step;
  wire logic            is_jump;
  wire logic            cond_met;
  wire logic            take;
  wire logic [PC_W-1:0] abs_target;
  wire logic [PC_W-1:0] rel_delta;
  wire logic [PC_W-1:0] rel_target;
  wire logic [PC_W-1:0] seq_target;
  wire logic [PC_W-1:0] next_pc;

  assign step    = instr_valid && clk_en;
  assign is_jump = (kind != scjd_pkg::SCJD_KIND_OTHER);
  // Exact pattern match; all-zero select holds only with no start latched
  assign cond_met = (start_latched == start_select);          // [RULE_06]
  assign take     = is_jump && cond_met;

  // Full register width passes through, no range limit on the target
  assign abs_target = jump_reg_select ? jump_reg1 : jump_reg0; // [RULE_02] [RULE_03]
  // Sign extension from bit 4 gives the minus-sixteen..fifteen span
  assign rel_delta  = {{(PC_W-5){rel_offset[4]}}, rel_offset}; // [RULE_05]
  assign rel_target = pc_add(instr_addr, rel_delta);           // [RULE_04]
  assign seq_target = pc_add(instr_addr, PC_W'(1));            // [RULE_09]

  assign next_pc = !take                             ? seq_target : // [RULE_09]
                   (kind == scjd_pkg::SCJD_KIND_ABS) ? abs_target : // [RULE_01]
                                                       rel_target;  // [RULE_04]

  // ----------------------------------------------------------------------
  // Program counter register
  // ----------------------------------------------------------------------
  // Whole state holds while clk_en is low and sys_rst is low, so pc_load stretches too; sys_rst still clears it
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      microcore_program_counter <= PC_W'(`SCJD_PC_RST);
      pc_load                   <= 1'b0;
      branch_taken              <= 1'b0;
    end
    else if (clk_en)
    begin
      pc_load <= instr_valid;
      if (instr_valid)
      begin
        microcore_program_counter <= next_pc; // [RULE_01] [RULE_04] [RULE_09]
        branch_taken              <= take;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  // Address of the last accepted word, kept only for the checks below;
  // it follows the same enable so a frozen stage keeps its reference
  logic [PC_W-1:0] last_addr;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      last_addr <= PC_W'(`SCJD_PC_RST);
    else if (step)
      last_addr <= instr_addr;
  end

  wire logic [PC_W-1:0] pc_diff;

  assign pc_diff = microcore_program_counter - last_addr;

  a_abs_load_target: assert property ( // [RULE_01]
    @(posedge clk) disable iff (sys_rst)
    (step && kind == scjd_pkg::SCJD_KIND_ABS && cond_met)
      |=> (branch_taken && pc_load &&
           microcore_program_counter == $past(abs_target)))
    else $error("absolute jump did not load the jump register value");

  a_abs_any_addr: assert property ( // [RULE_02]
    @(posedge clk) disable iff (sys_rst)
    (step && kind == scjd_pkg::SCJD_KIND_ABS && cond_met &&
     !jump_reg_select)
      |=> (microcore_program_counter == $past(jump_reg0)))
    else $error("absolute target was altered or limited");

  a_reg_select_one: assert property ( // [RULE_03]
    @(posedge clk) disable iff (sys_rst)
    (step && kind == scjd_pkg::SCJD_KIND_ABS && cond_met &&
     jump_reg_select)
      |=> (microcore_program_counter == $past(jump_reg1)))
    else $error("wrong jump register used for absolute target");

  a_rel_target_sum: assert property ( // [RULE_04]
    @(posedge clk) disable iff (sys_rst)
    (step && kind == scjd_pkg::SCJD_KIND_REL && cond_met)
      |=> (branch_taken &&
           pc_diff == {{(PC_W-5){$past(rel_offset[4])}},
                       $past(rel_offset)}))
    else $error("relative jump target is not address plus offset");

  a_rel_sign_back: assert property ( // [RULE_05]
    @(posedge clk) disable iff (sys_rst)
    (step && kind == scjd_pkg::SCJD_KIND_REL && cond_met &&
     rel_offset[4])
      |=> (pc_diff[PC_W-1:5] == {(PC_W-5){1'b1}}))
    else $error("negative relative offset did not move backwards");

  a_start_mismatch: assert property ( // [RULE_06]
    @(posedge clk) disable iff (sys_rst)
    (step && is_jump && start_latched != start_select)
      |=> !branch_taken)
    else $error("jump taken although start pattern differs");

  a_abs_decode_word: assert property ( // [RULE_07]
    @(posedge clk) disable iff (sys_rst)
    (instr_word[15:11] == 5'h07 && instr_word[3:0] == 4'h1)
      == (kind == scjd_pkg::SCJD_KIND_ABS))
    else $error("absolute start jump decoded wrongly");

  a_rel_decode_word: assert property ( // [RULE_08]
    @(posedge clk) disable iff (sys_rst)
    (instr_word[15:11] == 5'h01) == (kind == scjd_pkg::SCJD_KIND_REL) &&
    rel_offset == instr_word[4:0] && start_select == instr_word[10:5])
    else $error("relative start jump fields decoded wrongly");

  a_fall_through: assert property ( // [RULE_09]
    @(posedge clk) disable iff (sys_rst)
    (step && is_jump && !cond_met)
      |=> (!branch_taken && pc_load && pc_diff == PC_W'(1)))
    else $error("failed condition did not fall through");

  a_hold_frozen: assert property (
    @(posedge clk) disable iff (sys_rst)
    !clk_en |=> $stable(microcore_program_counter) && $stable(pc_load))
    else $error("state changed while clock enable was low");

endmodule // scjd_core

// ==== test_start_condition_jump_decode.sv ====
// Self-checking bench for the start-condition jump execute stage.
// Assumes scjd_core with PC_W of 10; inputs move on falling edges.
`timescale 1ns/10ps

module test_start_condition_jump_decode;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic        clk;
  logic        sys_rst;
  logic        clk_en;
  logic        instr_valid;
  logic [15:0] instr_word;
  logic [9:0]  instr_addr;
  logic [5:0]  start_latched;
  logic [9:0]  jump_reg0;
  logic [9:0]  jump_reg1;
  logic [9:0]  microcore_program_counter;
  logic        pc_load;
  logic        branch_taken;
  int          fails = 0;
  int          total_checks = 0;
  int          cycles = 0;

  scjd_core #(.PC_W(10)) scjd_core_inst
  (
    .clk                       (clk),
    .sys_rst                   (sys_rst),
    .clk_en                    (clk_en),
    .instr_valid               (instr_valid),
    .instr_word                (instr_word),
    .instr_addr                (instr_addr),
    .start_latched             (start_latched),
    .jump_reg0                 (jump_reg0),
    .jump_reg1                 (jump_reg1),
    .microcore_program_counter (microcore_program_counter),
    .pc_load                   (pc_load),
    .branch_taken              (branch_taken)
  );

  // 50 ns clock; a hang is cut off well past the expected run
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      finish_test;
    end
  end

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic check(input string name, input logic [9:0] seen,
                       input logic [9:0] expected);
    total_checks++;
    if (seen !== expected)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, expected, seen);
    end
  endtask

  // Words built by hand so a decoder slip cannot hide behind shared code
  function automatic logic [15:0] abs_word(input logic [5:0] sel,
                                           input logic r);
    return {5'h07, sel, r, 4'h1};
  endfunction

  function automatic logic [15:0] rel_word(input logic [5:0] sel,
                                           input logic [4:0] ofs);
    return {5'h01, sel, ofs};
  endfunction

  // One accepted word; the registered answer is judged a cycle later
  task automatic issue(input logic [15:0] w, input logic [9:0] a,
                       input logic [5:0] s, input logic [9:0] want,
                       input logic tk);
    instr_word = w;
    instr_addr = a;
    start_latched = s;
    instr_valid = 1'h1;
    @(negedge clk);
    check("pc", microcore_program_counter, want);
    check("pc_load", {9'h000, pc_load}, 10'h001);
    check("taken", {9'h000, branch_taken}, {9'h000, tk});
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_abs;
    jump_reg0 = 10'h3FF;
    jump_reg1 = 10'h000;
    issue(abs_word(6'h2A, 1'h0), 10'h010, 6'h2A, 10'h3FF, 1'h1);
    issue(abs_word(6'h2A, 1'h1), 10'h3FE, 6'h2A, 10'h000, 1'h1);
    jump_reg1 = 10'h155;
    issue(abs_word(6'h3F, 1'h1), 10'h000, 6'h3F, 10'h155, 1'h1);
  endtask

  // Offset extremes and a wrap below address zero
  task automatic t_rel;
    logic [4:0] ofs [4] = '{5'h10, 5'h0F, 5'h1F, 5'h01};
    logic [9:0] want [4] = '{10'h1F0, 10'h20F, 10'h1FF, 10'h201};
    for (int i = 0; i < 4; i++)
      issue(rel_word(6'h15, ofs[i]), 10'h200, 6'h15, want[i], 1'h1);
    issue(rel_word(6'h01, 5'h10), 10'h005, 6'h01, 10'h3F5, 1'h1);
  endtask

  // Every start bit alone, plus the all-zero code
  task automatic t_select;
    logic [5:0] sel;
    for (int i = 0; i < 6; i++)
    begin
      sel = 6'h01 << i;
      issue(rel_word(sel, 5'h02), 10'h040, sel, 10'h042, 1'h1);
      issue(rel_word(sel, 5'h02), 10'h040, sel ^ 6'h3F, 10'h041, 1'h0);
    end
    issue(abs_word(6'h00, 1'h0), 10'h040, 6'h00, 10'h3FF, 1'h1);
    issue(abs_word(6'h00, 1'h0), 10'h040, 6'h20, 10'h041, 1'h0);
  endtask

  // Near-miss encodings, and a start mismatch at the top address, must not branch
  task automatic t_decode;
    issue({5'h07, 6'h05, 1'h0, 4'h5}, 10'h100, 6'h05, 10'h101, 1'h0);
    issue({5'h03, 6'h05, 5'h04}, 10'h100, 6'h05, 10'h101, 1'h0);
    issue(abs_word(6'h05, 1'h1), 10'h3FF, 6'h04, 10'h000, 1'h0);
  endtask

  // Back-to-back words, then a frozen clock enable
  task automatic t_burst;
    jump_reg1 = 10'h2AA;
    instr_word = abs_word(6'h11, 1'h1);
    instr_addr = 10'h080;
    start_latched = 6'h11;
    instr_valid = 1'h1;
    @(negedge clk);
    check("pc", microcore_program_counter, 10'h2AA);
    issue(rel_word(6'h11, 5'h1E), 10'h2AA, 6'h11, 10'h2A8, 1'h1);
    clk_en = 1'h0;
    instr_word = rel_word(6'h11, 5'h04);
    repeat (2) @(negedge clk);
    check("pc", microcore_program_counter, 10'h2A8);
    check("pc_load", {9'h000, pc_load}, 10'h001);
    check("taken", {9'h000, branch_taken}, 10'h001);
    clk_en = 1'h1;
    instr_valid = 1'h0;
    @(negedge clk);
    check("pc", microcore_program_counter, 10'h2A8);
    check("pc_load", {9'h000, pc_load}, 10'h000);
    check("taken", {9'h000, branch_taken}, 10'h001);
  endtask

  // Mid-run reset wins over a low enable and clears every output
  task automatic t_reset;
    clk_en = 1'h0;
    sys_rst = 1'h1;
    @(negedge clk);
    check("pc", microcore_program_counter, 10'h000);
    check("pc_load", {9'h000, pc_load}, 10'h000);
    check("taken", {9'h000, branch_taken}, 10'h000);
    sys_rst = 1'h0;
    clk_en = 1'h1;
    issue(rel_word(6'h00, 5'h03), 10'h000, 6'h00, 10'h003, 1'h1);
  endtask

  // ------------------------------------------------------------------
  // Verdict
  // ------------------------------------------------------------------
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    clk = 1'h0;
    sys_rst = 1'h1;
    clk_en = 1'h1;
    instr_valid = 1'h0;
    instr_word = 16'h0000;
    instr_addr = 10'h000;
    start_latched = 6'h00;
    jump_reg0 = 10'h000;
    jump_reg1 = 10'h000;
    repeat (12) @(negedge clk);
    sys_rst = 1'h0;
    t_abs();
    t_rel();
    t_select();
    t_decode();
    t_burst();
    t_reset();
    finish_test();
  end
endmodule // test_start_condition_jump_decode
